// file: shared/adc_prio_pkg.sv
/*
  Package for the converter priority/monitor/trigger control block:
  register offsets, field positions, reset values, timing counts and carrier types.
  Assumes a 32-bit APB slave with one aligned word per register.
*/
package adc_prio_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_PRIORITY_CTRL = 8'h00;
  localparam logic [7:0] OFF_MONITOR0_CTRL = 8'h04;
  localparam logic [7:0] OFF_TRIGGER_RESET = 8'h08;
  localparam logic [7:0] OFF_MONITOR0_CMP  = 8'h0C;
  localparam logic [7:0] OFF_CLOCK_SETTING = 8'h10;
  localparam logic [7:0] OFF_RESULT_BASE   = 8'h20;
  localparam logic [7:0] OFF_RESULT_PRIO   = 8'h40;

  // Priority control fields
  localparam int PC_DONE_BIT  = 7;
  localparam int PC_BUSY_BIT  = 6;
  localparam int PC_START_BIT = 5;
  localparam int PC_CH_LSB    = 0;
  localparam int CH_W         = 4;

  // Monitor 0 fields
  localparam int M0_POL_BIT  = 5;
  localparam int M0_SEL_LSB  = 1;
  localparam int M0_SEL_W    = 4;
  localparam int M0_EN_BIT   = 0;
  localparam int M0_SEL_PRIO = 3;   // Top bit of the selector picks the priority result

  // Trigger register fields
  localparam int TR_PSRC_BIT = 7;
  localparam int TR_PEN_BIT  = 6;
  localparam int TR_NSRC_BIT = 5;
  localparam int TR_NEN_BIT  = 4;
  localparam int TR_KEY_LSB  = 0;
  localparam logic [1:0] KEY_FIRST  = 2'h2;
  localparam logic [1:0] KEY_SECOND = 2'h1;

  // Result register fields
  localparam int RES_W       = 10;
  localparam int RES_LSB     = 6;
  localparam int RES_OVR_BIT = 1;
  localparam int RES_RDY_BIT = 0;
  localparam int NUM_RESULTS = 8;

  // Reset values
  localparam logic [7:0] CLK_SETTING_RST = 8'h00;

  // Conversion time, in ns, and its length in 100 MHz cycles
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_TIME_NS  = 1000;
  localparam int CONV_CYCLES   = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // APB request carrier
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  // Converter request and its answer
  typedef struct packed {
    logic            valid;
    logic [CH_W-1:0] channel;
  } conv_req_t;

  typedef struct packed {
    logic             valid;
    logic [RES_W-1:0] data;
  } conv_res_t;

  typedef enum { CONV_IDLE, CONV_RUN } conv_state_t;

endpackage : adc_prio_pkg

// file: verilog/adc_conv_timer.sv
/*
  Conversion sequencer: models a converter that takes a fixed number of
  cycles and returns the sampled channel value.
  Assumes analog samples arrive as parallel digital words, one per channel.
*/
`timescale 1ns/100ps
`default_nettype none
module adc_conv_timer
  import adc_prio_pkg::*;
#(
  parameter int CYCLES = CONV_CYCLES
) (
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic                         soft_rst,
  input  wire conv_req_t                    req,
  input  wire logic [16*RES_W-1:0]          samples,
  output logic                              busy,
  output conv_res_t                         res
);

  typedef struct packed {
    conv_state_t     st;
    logic [15:0]     cnt;
    logic [CH_W-1:0] ch;
    conv_res_t       res;
  } timer_state_t;

  timer_state_t s;
  timer_state_t next_s;

  // Count down the conversion; result strobe lasts one cycle
  always_comb begin
    next_s = s;
    next_s.res.valid = 1'b0;
    case (s.st)
      CONV_IDLE: begin
        if (req.valid) begin
          next_s.st  = CONV_RUN;
          next_s.ch  = req.channel;
          next_s.cnt = 16'(CYCLES - 1);
        end
      end
      CONV_RUN: begin
        if (s.cnt == 16'h0000) begin
          next_s.st        = CONV_IDLE;
          next_s.res.valid = 1'b1;
          next_s.res.data  = samples[s.ch*RES_W +: RES_W];
        end else begin
          next_s.cnt = s.cnt - 16'h0001;
        end
      end
      default: next_s.st = CONV_IDLE;
    endcase
    if (soft_rst) begin
      next_s = '{st: CONV_IDLE, default: '0};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '{st: CONV_IDLE, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign busy = (s.st == CONV_RUN);
  assign res  = s.res;

endmodule : adc_conv_timer
`default_nettype wire

// file: verilog/adc_priority_monitor_trigger_ctrl.sv
/*
  Priority conversion, monitor 0 and hardware trigger control with APB access.
  Assumes a single 100 MHz clock, synchronous trigger inputs, and that the
  normal conversion engine outside consumes normal_hw_start.
*/
// Functional notes
// [R1] Done flag in priority control bit 7
// [R2] Reading the done flag clears it
// [R3] Busy flag in bit 6 while converting
// [R4] Writing 1 to bit 5 starts; reads 0
// [R5] Bits 3-0 pick channel 0 to 15
// [R6] Monitor 0 enable in bit 0
// [R7] Polarity 0: interrupt when result below compare
// [R8] Polarity 1: interrupt when result above compare
// [R9] Bits 4-1 pick result 0-7 or priority
// [R10] Bit 7: priority source external or timer
// [R11] Bit 6 enables priority hardware start
// [R12] Bit 5: normal source external or timer
// [R13] Bit 4 enables normal hardware start
// [R14] Software never shares external trigger between both
// [R15] Writing 10 then 01 causes soft reset
// [R16] Soft reset keeps only the clock setting
// [R17] Overrun flag set on overwrite, read clears
// [R18] Busy falls and done sets on store
`timescale 1ns/100ps
`default_nettype none
module adc_priority_monitor_trigger_ctrl
  import adc_prio_pkg::*;
#(
  parameter int CONV_LEN = CONV_CYCLES
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 ext_trigger,
  input  wire logic                 timer_match,
  input  wire logic [16*RES_W-1:0]  analog_samples,
  input  wire logic                 normal_result_valid,
  input  wire logic [2:0]           normal_result_index,
  input  wire logic [RES_W-1:0]     normal_result_data,
  output logic                      normal_hw_start,
  output logic                      monitor0_irq,
  output logic [7:0]                converter_clock_setting
);

  typedef struct packed {
    logic [CH_W-1:0]     priority_channel_select;
    logic                priority_done_flag;
    logic                monitor0_enable;
    logic                monitor0_polarity;
    logic [M0_SEL_W-1:0] monitor0_target_select;
    logic [RES_W-1:0]    monitor0_compare;
    logic                priority_hw_source;
    logic                priority_hw_enable;
    logic                normal_hw_source;
    logic                normal_hw_enable;
    logic                key_armed;
    logic                soft_reset;
    logic [7:0]          clk_setting;
    logic [NUM_RESULTS-1:0][RES_W-1:0] result;
    logic [NUM_RESULTS-1:0] result_ready;
    logic [NUM_RESULTS-1:0] result_overrun;
    logic [RES_W-1:0]    prio_result;
    logic                prio_ready;
    logic                prio_overrun;
    logic [31:0]         rdata;
    logic                irq;
    logic                ext_q;
    logic                tmr_q;
  } ctrl_state_t;

  ctrl_state_t s;
  ctrl_state_t next_s;

  conv_req_t  conv_req;
  conv_res_t  conv_res;
  logic       conv_busy;
  logic       wr_en;
  logic       rd_en;
  logic       ext_rise;
  logic       tmr_rise;
  logic       prio_hw_fire;
  logic       sw_start;
  logic [RES_W-1:0] mon_value;
  logic       mon_fresh;

  // Pack a result word with its overrun and stored flags
  function automatic logic [31:0] result_word(input logic [RES_W-1:0] d,
                                              input logic ovr, input logic rdy);
    logic [31:0] w;
    w = '0;
    w[RES_LSB +: RES_W] = d;
    w[RES_OVR_BIT]      = ovr;
    w[RES_RDY_BIT]      = rdy;
    return w;
  endfunction : result_word

  // Every APB transfer completes in its first access cycle
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & penable & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // Trigger edges, sources chosen by the trigger register
  assign ext_rise     = ext_trigger & ~s.ext_q;
  assign tmr_rise     = timer_match & ~s.tmr_q;
  assign prio_hw_fire = s.priority_hw_enable &                               // R11
                        (s.priority_hw_source ? tmr_rise : ext_rise);        // R10
  assign normal_hw_start = s.normal_hw_enable &                              // R13
                           (s.normal_hw_source ? tmr_rise : ext_rise);       // R12
  assign sw_start = wr_en & (paddr == OFF_PRIORITY_CTRL) & pwdata[PC_START_BIT]; // R4

  // Starts while busy are dropped; the sequencer ignores them
  assign conv_req.valid   = (sw_start | prio_hw_fire) & ~conv_busy & ~s.soft_reset;
  assign conv_req.channel = sw_start ? pwdata[PC_CH_LSB +: CH_W]
                                     : s.priority_channel_select;            // R5

  adc_conv_timer #(
    .CYCLES (CONV_LEN)
  ) u_conv (
    .clk      (clk),
    .rst      (rst),
    .soft_rst (s.soft_reset),
    .req      (conv_req),
    .samples  (analog_samples),
    .busy     (conv_busy),
    .res      (conv_res)
  );

  // Monitor source: a freshly stored value in the selected register
  always_comb begin
    if (s.monitor0_target_select[M0_SEL_PRIO]) begin                        // R9
      mon_value = conv_res.data;
      mon_fresh = conv_res.valid;
    end else begin
      mon_value = normal_result_data;
      mon_fresh = normal_result_valid &&
                  (normal_result_index == s.monitor0_target_select[2:0]);
    end
  end

  // Register file, flags and soft reset
  always_comb begin
    next_s = s;
    next_s.ext_q = ext_trigger;
    next_s.tmr_q = timer_match;
    next_s.soft_reset = 1'b0;
    next_s.irq = 1'b0;

    // Compare on each store; pulse the interrupt one cycle
    if (s.monitor0_enable && mon_fresh) begin                                // R6
      if (!s.monitor0_polarity) begin
        next_s.irq = (mon_value < s.monitor0_compare);                       // R7
      end else begin
        next_s.irq = (mon_value > s.monitor0_compare);                       // R8
      end
    end

    // Read side effects go first so a store in the same cycle wins
    if (rd_en) begin
      case (paddr)
        OFF_PRIORITY_CTRL: next_s.priority_done_flag = 1'b0;                 // R2
        OFF_RESULT_PRIO: begin
          next_s.prio_ready   = 1'b0;
          next_s.prio_overrun = 1'b0;                                        // R17
        end
        default: begin
          for (int i = 0; i < NUM_RESULTS; i++) begin
            if (paddr == OFF_RESULT_BASE + 8'(4 * i)) begin
              next_s.result_ready[i]   = 1'b0;
              next_s.result_overrun[i] = 1'b0;                               // R17
            end
          end
        end
      endcase
    end

    // Priority result store: done flag sets as busy falls
    if (conv_res.valid) begin
      next_s.prio_result        = conv_res.data;
      next_s.prio_overrun       = s.prio_ready | s.prio_overrun;             // R17
      next_s.prio_ready         = 1'b1;
      next_s.priority_done_flag = 1'b1;                                      // R18
    end
    if (normal_result_valid) begin
      next_s.result[normal_result_index] = normal_result_data;
      next_s.result_overrun[normal_result_index] =
        s.result_ready[normal_result_index] | s.result_overrun[normal_result_index];
      next_s.result_ready[normal_result_index] = 1'b1;
    end

    // Writes
    if (wr_en) begin
      case (paddr)
        OFF_PRIORITY_CTRL: begin
          next_s.priority_channel_select = pwdata[PC_CH_LSB +: CH_W];        // R5
        end
        OFF_MONITOR0_CTRL: begin
          next_s.monitor0_enable        = pwdata[M0_EN_BIT];                 // R6
          next_s.monitor0_target_select = pwdata[M0_SEL_LSB +: M0_SEL_W];    // R9
          next_s.monitor0_polarity      = pwdata[M0_POL_BIT];
        end
        OFF_MONITOR0_CMP: next_s.monitor0_compare = pwdata[RES_W-1:0];
        OFF_CLOCK_SETTING: next_s.clk_setting = pwdata[7:0];
        OFF_TRIGGER_RESET: begin
          next_s.priority_hw_source = pwdata[TR_PSRC_BIT];                   // R10
          next_s.priority_hw_enable = pwdata[TR_PEN_BIT];                    // R11
          next_s.normal_hw_source   = pwdata[TR_NSRC_BIT];                   // R12
          next_s.normal_hw_enable   = pwdata[TR_NEN_BIT];                    // R13
          // Key: 10 arms, 01 right after fires; anything else disarms
          next_s.key_armed  = (pwdata[TR_KEY_LSB +: 2] == KEY_FIRST);        // R15
          next_s.soft_reset = s.key_armed &&
                              (pwdata[TR_KEY_LSB +: 2] == KEY_SECOND);       // R15
        end
        default: ;
      endcase
    end

    // Read data, registered so it is stable in the access cycle
    next_s.rdata = '0;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        OFF_PRIORITY_CTRL: begin
          next_s.rdata[PC_DONE_BIT] = s.priority_done_flag | conv_res.valid; // R1
          next_s.rdata[PC_BUSY_BIT] = conv_busy;                             // R3
          next_s.rdata[PC_CH_LSB +: CH_W] = s.priority_channel_select;
        end
        OFF_MONITOR0_CTRL: begin
          next_s.rdata[M0_POL_BIT]             = s.monitor0_polarity;
          next_s.rdata[M0_SEL_LSB +: M0_SEL_W] = s.monitor0_target_select;
          next_s.rdata[M0_EN_BIT]              = s.monitor0_enable;
        end
        OFF_TRIGGER_RESET: begin
          next_s.rdata[TR_PSRC_BIT] = s.priority_hw_source;
          next_s.rdata[TR_PEN_BIT]  = s.priority_hw_enable;
          next_s.rdata[TR_NSRC_BIT] = s.normal_hw_source;
          next_s.rdata[TR_NEN_BIT]  = s.normal_hw_enable;
        end
        OFF_MONITOR0_CMP:  next_s.rdata[RES_W-1:0] = s.monitor0_compare;
        OFF_CLOCK_SETTING: next_s.rdata[7:0] = s.clk_setting;
        OFF_RESULT_PRIO:
          next_s.rdata = result_word(s.prio_result, s.prio_overrun, s.prio_ready);
        default: begin
          for (int i = 0; i < NUM_RESULTS; i++) begin
            if (paddr == OFF_RESULT_BASE + 8'(4 * i)) begin
              next_s.rdata = result_word(s.result[i], s.result_overrun[i],
                                         s.result_ready[i]);
            end
          end
        end
      endcase
    end

    // Soft reset clears everything but the converter clock setting; the trigger edge history reloads from the inputs
    if (s.soft_reset) begin                                                  // R16
      next_s = '0;
      next_s.clk_setting = s.clk_setting;
      next_s.ext_q = ext_trigger;
      next_s.tmr_q = timer_match;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.clk_setting <= CLK_SETTING_RST;
    end else begin
      s <= next_s;
    end
  end

  // The start bit has no storage, so it reads 0
  assign prdata                  = s.rdata;                                  // R4
  assign monitor0_irq            = s.irq;
  assign converter_clock_setting = s.clk_setting;

endmodule : adc_priority_monitor_trigger_ctrl
`default_nettype wire

// file: testbench/trig_source_model.sv
/*
  Model of the trigger sources: external trigger pin and timer match.
  Assumes the bench asks for each pulse with a one-cycle fire request.
*/
`timescale 1ns/100ps
`default_nettype none
module trig_source_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       fire_ext,
  input  wire logic       fire_tmr,
  input  wire logic [1:0] hold,
  output logic            ext_trigger,
  output logic            timer_match
);
  logic [2:0] cnt_e;
  logic [2:0] cnt_t;

  // Level held one to four cycles, so prompt and slow sources both occur
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_e <= 3'h0;
      cnt_t <= 3'h0;
    end else begin
      cnt_e <= fire_ext ? 3'(hold) + 3'h1 : (cnt_e != 3'h0 ? cnt_e - 3'h1 : 3'h0);
      cnt_t <= fire_tmr ? 3'(hold) + 3'h1 : (cnt_t != 3'h0 ? cnt_t - 3'h1 : 3'h0);
    end
  end

  // Both lines idle low between pulses
  assign ext_trigger = (cnt_e != 3'h0);
  assign timer_match = (cnt_t != 3'h0);
endmodule : trig_source_model
`default_nettype wire

// file: testbench/adc_prio_ctrl_asserts.sv
/*
  Port checker for the priority control block.
  Assumes binding to the block top; APB answers with zero wait states.
*/
`timescale 1ns/100ps
`default_nettype none
module adc_prio_ctrl_asserts
  import adc_prio_pkg::*;
#(
  parameter int CONV_LEN = CONV_CYCLES
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        ext_trigger,
  input wire logic        timer_match,
  input wire logic        normal_hw_start,
  input wire logic        monitor0_irq,
  input wire logic [7:0]  converter_clock_setting
);
  logic rd_acc;
  logic wr_clk;

  // Access-phase qualifiers
  assign rd_acc = psel && penable && !pwrite;
  assign wr_clk = psel && penable && pwrite && paddr == OFF_CLOCK_SETTING;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ready_ok_a: assert property (pready && !pslverr)
    else $error("apb answer not ready or errored");
  rdata_idle_a: assert property (!psel |-> prdata == 32'h0)
    else $error("read data not zero while idle");
  start_reads_zero_a: assert property (rd_acc && paddr == OFF_PRIORITY_CTRL |->
    prdata[PC_START_BIT] == 1'b0 && prdata[31:8] == 24'h0)
    else $error("priority start bit read back nonzero");
  mon0_reserved_a: assert property (rd_acc && paddr == OFF_MONITOR0_CTRL |->
    prdata[31:6] == 26'h0)
    else $error("monitor control reserved bits nonzero");
  key_reads_zero_a: assert property (rd_acc && paddr == OFF_TRIGGER_RESET |->
    prdata[3:0] == 4'h0 && prdata[31:8] == 24'h0)
    else $error("reset key field read back nonzero");
  nstart_edge_a: assert property (normal_hw_start |->
    $rose(ext_trigger) || $rose(timer_match))
    else $error("normal start without a trigger edge");
  clock_keep_a: assert property (!wr_clk |=> $stable(converter_clock_setting))
    else $error("clock setting changed without a write");
  clock_load_a: assert property (wr_clk |=>
    converter_clock_setting == $past(pwdata[7:0]))
    else $error("clock setting not loaded by write");

  // Main scenarios reached
  cover property (normal_hw_start);
  cover property (monitor0_irq);
  cover property (rd_acc && paddr == OFF_RESULT_PRIO);
endmodule : adc_prio_ctrl_asserts

bind adc_priority_monitor_trigger_ctrl adc_prio_ctrl_asserts #(.CONV_LEN(CONV_LEN))
  i_adc_prio_ctrl_asserts (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .ext_trigger(ext_trigger), .timer_match(timer_match),
  .normal_hw_start(normal_hw_start), .monitor0_irq(monitor0_irq),
  .converter_clock_setting(converter_clock_setting));
`default_nettype wire

// file: testbench/adc_priority_monitor_trigger_ctrl_tb.sv
/*
  Self-checking bench for the priority control block.
  Assumes the trigger source model and the bound port checker.
*/
`timescale 1ns/100ps
`default_nettype none
module adc_priority_monitor_trigger_ctrl_tb;
  import adc_prio_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr;
  logic ext_trigger, timer_match, fire_ext, fire_tmr, normal_result_valid;
  logic normal_hw_start, monitor0_irq;
  logic [7:0] paddr, clk_set;
  logic [31:0] pwdata, prdata, r;
  logic [16*RES_W-1:0] analog_samples;
  logic [2:0] nidx;
  logic [RES_W-1:0] ndata;
  logic [1:0] hold;
  int n_mismatch, compares, n_irq, n_nst;

  adc_priority_monitor_trigger_ctrl #(.CONV_LEN(4)) i_adc_priority_monitor_trigger_ctrl (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_trigger(ext_trigger), .timer_match(timer_match), .analog_samples(analog_samples),
    .normal_result_valid(normal_result_valid), .normal_result_index(nidx),
    .normal_result_data(ndata), .normal_hw_start(normal_hw_start),
    .monitor0_irq(monitor0_irq), .converter_clock_setting(clk_set));
  trig_source_model i_trig_source_model (.clk(clk), .rst(rst), .fire_ext(fire_ext),
    .fire_tmr(fire_tmr), .hold(hold), .ext_trigger(ext_trigger), .timer_match(timer_match));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Event counters for pulse outputs, sampled mid-cycle where they are settled
  always @(negedge clk) begin
    if (monitor0_irq === 1'b1) n_irq++;
    if (normal_hw_start === 1'b1) n_nst++;
  end

  task automatic test_done();
    if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    logic rdy;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    // Ready and read data are taken as they stand just before the closing edge,
    // since the design's registers move in the same time step as that edge
    do begin
      @(negedge clk);
      rdy = pready;
      r = prdata;
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 50);
    if (rdy !== 1'b1) begin
      n_mismatch++;
      $display("mismatch at %0t: no pready", $time);
      test_done();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(r, e);
  endtask : rd_chk

  task automatic store(input logic [2:0] i, input logic [RES_W-1:0] d);
    @(posedge clk);
    normal_result_valid <= 1'b1;
    nidx <= i;
    ndata <= d;
    @(posedge clk);
    normal_result_valid <= 1'b0;
  endtask : store

  task automatic fire(input logic tmr);
    @(posedge clk);
    if (tmr) fire_tmr <= 1'b1;
    else fire_ext <= 1'b1;
    hold <= 2'($urandom_range(3, 0));
    @(posedge clk);
    fire_ext <= 1'b0;
    fire_tmr <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : fire

  function automatic logic [RES_W-1:0] smp(input logic [3:0] ch);
    return analog_samples[ch*RES_W +: RES_W];
  endfunction : smp

  // Poll until busy drops, then expect done set with the channel kept
  task automatic wait_done(input logic [3:0] ch);
    int n;
    n = 0;
    do begin
      apb(1'b0, OFF_PRIORITY_CTRL, 32'h0);
      n++;
    end while (r[PC_BUSY_BIT] === 1'b1 && n < 20);
    chk(r, {24'h0, 4'h8, ch});
    rd_chk(OFF_PRIORITY_CTRL, {28'h0, ch});
  endtask : wait_done

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    test_done();
  end

  initial begin
    logic [3:0] sel;
    logic pol, en;
    logic [RES_W-1:0] cmp, dat;
    logic [2:0] idx;
    int base;
    {rst, psel, penable, pwrite, paddr, pwdata, normal_result_valid} = '0;
    {fire_ext, fire_tmr, hold, nidx, ndata} = '0;
    rst = 1'b1;
    void'($urandom(32'hE23C));
    for (int i = 0; i < 16; i++) analog_samples[i*RES_W +: RES_W] = RES_W'($urandom);
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    // Reset values, then an unmapped place that ignores writes
    for (int i = 0; i < 5; i++) rd_chk(8'(i * 4), 32'h0);
    apb(1'b1, 8'h7C, 32'hFFFFFFFF);
    rd_chk(8'h7C, 32'h0);
    // Every channel by software start, monitor watching the priority result
    apb(1'b1, OFF_MONITOR0_CMP, 32'h200);
    apb(1'b1, OFF_MONITOR0_CTRL, 32'h11);
    for (int c = 0; c < 16; c++) begin
      base = n_irq;
      apb(1'b1, OFF_PRIORITY_CTRL, 32'h20 | c);
      apb(1'b0, OFF_PRIORITY_CTRL, 32'h0);
      chk(r[7:4], 4'h4);
      wait_done(4'(c));
      rd_chk(OFF_RESULT_PRIO, {16'h0, smp(4'(c)), 6'h01});
      chk(n_irq - base, smp(4'(c)) < 10'h200);
    end
    // Monitor on normal stores, random with equal-value corners
    for (int i = 0; i < 24; i++) begin
      {sel, pol, en, idx} = 9'($urandom);
      cmp = RES_W'($urandom);
      dat = (i < 3) ? cmp : RES_W'($urandom);
      apb(1'b1, OFF_MONITOR0_CMP, {22'h0, cmp});
      apb(1'b1, OFF_MONITOR0_CTRL, {26'h0, pol, sel, en});
      base = n_irq;
      store(idx, dat);
      repeat (3) @(posedge clk);
      chk(n_irq - base, en && !sel[3] && sel[2:0] == idx && (pol ? dat > cmp : dat < cmp));
    end
    // Overwrite before read, then read clears the flags
    apb(1'b0, OFF_RESULT_BASE, 32'h0);
    store(3'h0, 10'h155);
    store(3'h0, 10'h2AA);
    rd_chk(OFF_RESULT_BASE, {16'h0, 10'h2AA, 6'h03});
    rd_chk(OFF_RESULT_BASE, {16'h0, 10'h2AA, 6'h00});
    // Priority hardware start, then normal hardware start, each with the other kept off the shared trigger
    apb(1'b1, OFF_PRIORITY_CTRL, 32'h3);
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, OFF_TRIGGER_RESET, {24'h0, p[0], p[1], 6'h0});
      fire(p[0]);
      if (p[1]) wait_done(4'h3);
      fire(!p[0]);
      rd_chk(OFF_PRIORITY_CTRL, 32'h3);
    end
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, OFF_TRIGGER_RESET, {26'h0, p[0], p[1], 4'h0});
      base = n_nst;
      fire(p[0]);
      fire(!p[0]);
      chk(n_nst - base, p[1]);
    end
    // Soft reset: a broken key sequence first, then the proper one
    apb(1'b1, OFF_CLOCK_SETTING, 32'hA5);
    apb(1'b1, OFF_MONITOR0_CTRL, 32'h2B);
    apb(1'b1, OFF_TRIGGER_RESET, 32'h32);
    apb(1'b1, OFF_TRIGGER_RESET, 32'h30);
    apb(1'b1, OFF_TRIGGER_RESET, 32'h01);
    rd_chk(OFF_MONITOR0_CTRL, 32'h2B);
    apb(1'b1, OFF_TRIGGER_RESET, 32'h22);
    apb(1'b1, OFF_TRIGGER_RESET, 32'h31);
    repeat (2) @(posedge clk);
    rd_chk(OFF_MONITOR0_CTRL, 32'h0);
    rd_chk(OFF_TRIGGER_RESET, 32'h0);
    rd_chk(OFF_CLOCK_SETTING, 32'hA5);
    test_done();
  end
endmodule : adc_priority_monitor_trigger_ctrl_tb
`default_nettype wire
